// [pflc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pflc_defs.svh"

module pflc_ctrl (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    output var  logic [16:0]       byte_address_bus,
    output var  pflc_pkg::pflc_pin_t flash_ctl,
    output var  logic [7:0]        dq_out,
    input  wire logic [7:0]        dq_in
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    pflc_pkg::pflc_op_t    cop_reg,   cop_next;
    logic [16:0]           addr_reg,  addr_next;
    logic [7:0]            wdata_reg, wdata_next;
    logic                  start_reg, start_next;
    logic                  pready_reg, pready_next;
    logic                  pslverr_reg, pslverr_next;
    logic [31:0]           prdata_reg, prdata_next;
    pflc_pkg::pflc_state_t state_reg, state_next;
    pflc_pkg::pflc_op_t    op_reg,    op_next;
    logic [2:0]            step_reg,  step_next;
    logic [3:0]            cnt_reg,   cnt_next;
    logic                  poll_reg,  poll_next;
    logic                  busy_reg,  busy_next;
    logic                  done_reg,  done_next;
    logic                  err_reg,   err_next;
    logic [7:0]            rdata_reg, rdata_next;
    logic [7:0]            prev_reg,  prev_next;
    logic                  prev_ok_reg, prev_ok_next;
    logic [16:0]           bus_reg,   bus_next;
    pflc_pkg::pflc_pin_t   ctl_reg,   ctl_next;
    logic [7:0]            dqo_reg,   dqo_next;
    logic [7:0]            dq_s1, dq_s2, dq_s3;
    logic [2:0]            sector_number_bits;
    pflc_pkg::pflc_cyc_t   cyc;
    logic                  access;

    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign byte_address_bus = bus_reg;
    assign flash_ctl        = ctl_reg;
    assign dq_out           = dqo_reg;
    assign sector_number_bits = addr_reg[`PFLC_SA_MSB:`PFLC_SA_LSB];

    // ----------------------------------------------------------------
    // command sequence table
    // ----------------------------------------------------------------
    function automatic pflc_pkg::pflc_cyc_t pflc_seq(input pflc_pkg::pflc_op_t op,
                                                     input logic [2:0] step,
                                                     input logic [16:0] addr,
                                                     input logic [7:0] data,
                                                     input logic [2:0] sa);
        pflc_pkg::pflc_cyc_t c;
        logic [7:0]          cmd;
        cmd = (op == pflc_pkg::OP_PROG) ? `PFLC_CMD_PROG :
              (op == pflc_pkg::OP_IDREAD) ? `PFLC_CMD_IDENT : `PFLC_CMD_ERASE;
        c = '{1'b0, `PFLC_UNLK_A1, `PFLC_UNLK_D1, 1'b0};
        if (op == pflc_pkg::OP_READ) begin
            c = '{1'b1, addr, 8'h00, 1'b1};
        end else if (op == pflc_pkg::OP_RESET) begin
            c = '{1'b0, addr, `PFLC_CMD_RESET, 1'b1};
        end else begin
            case (step)
                3'h1, 3'h4: c = '{1'b0, `PFLC_UNLK_A2, `PFLC_UNLK_D2, 1'b0};
                3'h2:       c = '{1'b0, `PFLC_UNLK_A1, cmd, 1'b0};
                default:    c = '{1'b0, `PFLC_UNLK_A1, `PFLC_UNLK_D1, 1'b0};
            endcase
            if (op == pflc_pkg::OP_PROG && step == 3'h3) begin
                c = '{1'b0, addr, data, 1'b1};
            end
            if (op == pflc_pkg::OP_IDREAD && step == 3'h3) begin
                c = '{1'b1, addr, 8'h00, 1'b0};
            end
            if (op == pflc_pkg::OP_IDREAD && step == 3'h4) begin
                c = '{1'b0, addr, `PFLC_CMD_RESET, 1'b1};
            end
            if (op == pflc_pkg::OP_CERASE && step == 3'h5) begin
                c = '{1'b0, `PFLC_UNLK_A1, `PFLC_CMD_CHIP, 1'b1};
            end
            // sector chosen by top address bits
            if (op == pflc_pkg::OP_SERASE && step == 3'h5) begin
                c = '{1'b0, {sa, 14'h0000}, `PFLC_CMD_SECT, 1'b1};
            end
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    // one wait state: pready rises the cycle after the access phase starts
    assign access = psel & penable & ~pready_reg;

    always_comb begin
        cop_next     = cop_reg;
        addr_next    = addr_reg;
        wdata_next   = wdata_reg;
        start_next   = 1'b0;
        pready_next  = access;
        pslverr_next = 1'b0;
        prdata_next  = prdata_reg;
        if (access && pwrite) begin
            // writes while busy are dropped so the running sequence keeps its operands
            if (paddr == `PFLC_OFS_CTRL) begin
                if (!busy_reg && !start_reg && pwdata[`PFLC_CTRL_OP_MSB:`PFLC_CTRL_OP_LSB] <= 3'h5) begin
                    cop_next   = pflc_pkg::pflc_op_t'(pwdata[`PFLC_CTRL_OP_MSB:`PFLC_CTRL_OP_LSB]);
                    start_next = pwdata[`PFLC_CTRL_GO];
                end
            end else if (paddr == `PFLC_OFS_ADDR) begin
                if (!busy_reg) addr_next = pwdata[16:0];
            end else if (paddr == `PFLC_OFS_WDATA) begin
                if (!busy_reg) wdata_next = pwdata[7:0];
            end else if (paddr != `PFLC_OFS_STAT) begin
                pslverr_next = 1'b1;
            end
        end else if (access) begin
            if (paddr == `PFLC_OFS_CTRL) begin
                prdata_next = {25'h0000000, cop_reg, 4'h0};
            end else if (paddr == `PFLC_OFS_ADDR) begin
                prdata_next = {15'h0000, addr_reg};
            end else if (paddr == `PFLC_OFS_WDATA) begin
                prdata_next = {24'h000000, wdata_reg};
            end else if (paddr == `PFLC_OFS_STAT) begin
                prdata_next = {16'h0000, rdata_reg, 5'h00, err_reg, done_reg, busy_reg | start_reg};
            end else begin
                prdata_next  = 32'h00000000;
                pslverr_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cop_reg     <= pflc_pkg::OP_READ;
            addr_reg    <= `PFLC_ADDR_RST;
            wdata_reg   <= `PFLC_WDATA_RST;
            start_reg   <= 1'b0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else if (clk_en) begin
            cop_reg     <= cop_next;
            addr_reg    <= addr_next;
            wdata_reg   <= wdata_next;
            start_reg   <= start_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // ----------------------------------------------------------------
    // data pin synchroniser
    // ----------------------------------------------------------------
    // three stages; a value counts only once stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            dq_s3 <= 8'h00;
        end else if (clk_en) begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
        end
    end

    // ----------------------------------------------------------------
    // flash bus engine
    // ----------------------------------------------------------------
    always_comb begin
        cyc = poll_reg ? '{1'b1, addr_reg, 8'h00, 1'b1} :
                         pflc_seq(op_reg, step_reg, addr_reg, wdata_reg, sector_number_bits);
    end

    always_comb begin
        state_next   = state_reg;
        op_next      = op_reg;
        step_next    = step_reg;
        cnt_next     = cnt_reg;
        poll_next    = poll_reg;
        busy_next    = busy_reg;
        done_next    = done_reg;
        err_next     = err_reg;
        rdata_next   = rdata_reg;
        prev_next    = prev_reg;
        prev_ok_next = prev_ok_reg;
        bus_next     = bus_reg;
        ctl_next     = ctl_reg;
        dqo_next     = dqo_reg;
        case (state_reg)
            pflc_pkg::ST_IDLE: begin
                ctl_next = '{1'b1, 1'b1, 1'b1, 1'b1};
                if (start_reg) begin
                    op_next    = cop_reg;
                    step_next  = 3'h0;
                    poll_next  = 1'b0;
                    busy_next  = 1'b1;
                    done_next  = 1'b0;
                    err_next   = 1'b0;
                    state_next = pflc_pkg::ST_SETUP;
                end
            end
            pflc_pkg::ST_SETUP: begin
                bus_next = cyc.addr;
                // select first, output gate stays high for writes
                ctl_next = '{1'b0, 1'b1, 1'b1, cyc.rd};
                if (!cyc.rd) dqo_next = cyc.data;
                // full count: the strobe falls one edge after this load, so no minus one here
                cnt_next = cyc.rd ? 4'(`PFLC_ACC_CYC + `PFLC_SYNC_DEPTH) : 4'(`PFLC_WP_CYC);
                state_next = pflc_pkg::ST_STROBE;
            end
            pflc_pkg::ST_STROBE: begin
                // reads never pull the write strobe
                ctl_next.oe_n = ~cyc.rd;
                ctl_next.we_n = cyc.rd;
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (!cyc.rd || dq_s2 == dq_s3) begin
                    // byte taken while select and output gate are low
                    if (cyc.rd) rdata_next = dq_s3;
                    ctl_next.oe_n = 1'b1;
                    ctl_next.we_n = 1'b1;
                    state_next    = pflc_pkg::ST_GAP;
                end
            end
            default: begin
                // releasing select between cycles lets the device latch each write
                ctl_next   = '{1'b1, 1'b1, 1'b1, 1'b1};
                state_next = pflc_pkg::ST_SETUP;
                if (poll_reg) begin
                    // done when bit 6 stops toggling; bit 5 with toggling is a fault
                    if (prev_ok_reg && rdata_reg[`PFLC_DQ_TOGGLE] == prev_reg[`PFLC_DQ_TOGGLE]) begin
                        busy_next  = 1'b0;
                        done_next  = 1'b1;
                        poll_next  = 1'b0;
                        state_next = pflc_pkg::ST_IDLE;
                    end else if (prev_ok_reg && rdata_reg[`PFLC_DQ_ERR] && prev_reg[`PFLC_DQ_ERR]) begin
                        // reset command after a failed operation
                        err_next  = 1'b1;
                        poll_next = 1'b0;
                        op_next   = pflc_pkg::OP_RESET;
                        step_next = 3'h0;
                    end else begin
                        prev_next    = rdata_reg;
                        prev_ok_next = 1'b1;
                    end
                end else if (!cyc.last) begin
                    step_next = step_reg + 3'h1;
                end else if (op_reg == pflc_pkg::OP_PROG || op_reg == pflc_pkg::OP_SERASE ||
                             op_reg == pflc_pkg::OP_CERASE) begin
                    // poll until the device is back in read mode
                    poll_next    = 1'b1;
                    prev_ok_next = 1'b0;
                end else begin
                    busy_next  = 1'b0;
                    done_next  = 1'b1;
                    state_next = pflc_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= pflc_pkg::ST_IDLE;
            op_reg      <= pflc_pkg::OP_READ;
            step_reg    <= 3'h0;
            cnt_reg     <= 4'h0;
            poll_reg    <= 1'b0;
            busy_reg    <= 1'b0;
            done_reg    <= 1'b0;
            err_reg     <= 1'b0;
            rdata_reg   <= 8'h00;
            prev_reg    <= 8'h00;
            prev_ok_reg <= 1'b0;
            bus_reg     <= `PFLC_ADDR_RST;
            ctl_reg     <= '{1'b1, 1'b1, 1'b1, 1'b1};
            dqo_reg     <= 8'h00;
        end else if (clk_en) begin
            state_reg   <= state_next;
            op_reg      <= op_next;
            step_reg    <= step_next;
            cnt_reg     <= cnt_next;
            poll_reg    <= poll_next;
            busy_reg    <= busy_next;
            done_reg    <= done_next;
            err_reg     <= err_next;
            rdata_reg   <= rdata_next;
            prev_reg    <= prev_next;
            prev_ok_reg <= prev_ok_next;
            bus_reg     <= bus_next;
            ctl_reg     <= ctl_next;
            dqo_reg     <= dqo_next;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence unlock_first_s;
        bus_reg == `PFLC_UNLK_A1 && dqo_reg == `PFLC_UNLK_D1 && !ctl_reg.dq_oe_n;
    endsequence

    sequence write_pulse_s;
        !ctl_reg.we_n [*2] ##1 ctl_reg.we_n;
    endsequence

    rd_we_high_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        !ctl_reg.oe_n |-> ctl_reg.we_n) else $error("write strobe low during read");
    wr_oe_high_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        !ctl_reg.we_n |-> ctl_reg.oe_n && !ctl_reg.ce_n && !ctl_reg.dq_oe_n) else $error("bad write strobes");
    rd_select_low_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        !ctl_reg.oe_n |-> !ctl_reg.ce_n && ctl_reg.dq_oe_n) else $error("read without select or with drive");
    unlock_lead_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        ($rose(busy_reg) && op_reg != pflc_pkg::OP_READ && op_reg != pflc_pkg::OP_RESET) |=> unlock_first_s)
        else $error("command not led by unlock cycle");
    id_exit_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        ($rose(done_reg) && op_reg == pflc_pkg::OP_IDREAD) |-> dqo_reg == `PFLC_CMD_RESET)
        else $error("id mode left without reset command");
    poll_done_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        ($rose(done_reg) && $past(poll_reg)) |-> rdata_reg[`PFLC_DQ_TOGGLE] == prev_reg[`PFLC_DQ_TOGGLE])
        else $error("poll ended while toggling");
    poll_no_write_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        (poll_reg && state_reg == pflc_pkg::ST_STROBE) |-> ctl_reg.we_n && ctl_reg.dq_oe_n)
        else $error("write issued while polling");
    strobe_width_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        $fell(ctl_reg.we_n) |-> write_pulse_s) else $error("write pulse width wrong");
    idle_release_a: assert property (@(posedge clk) disable iff (!arst_n || !clk_en)
        state_reg == pflc_pkg::ST_IDLE |=> ctl_reg.ce_n && ctl_reg.dq_oe_n) else $error("select held while idle");
endmodule
`default_nettype wire

// [pflc_defs.svh]
`ifndef PFLC_DEFS_SVH
`define PFLC_DEFS_SVH

// ----------------------------------------------------------------
// register map (apb byte offsets)
// ----------------------------------------------------------------
`define PFLC_OFS_CTRL    12'h000
`define PFLC_OFS_ADDR    12'h004
`define PFLC_OFS_WDATA   12'h008
`define PFLC_OFS_STAT    12'h00C
`define PFLC_CTRL_GO     0
`define PFLC_CTRL_OP_LSB 4
`define PFLC_CTRL_OP_MSB 6
`define PFLC_STAT_BUSY   0
`define PFLC_STAT_DONE   1
`define PFLC_STAT_ERR    2
`define PFLC_STAT_RD_LSB 8
`define PFLC_ADDR_RST    17'h00000
`define PFLC_WDATA_RST   8'h00

// ----------------------------------------------------------------
// command cycles and status bits
// ----------------------------------------------------------------
`define PFLC_UNLK_A1     17'h05555
`define PFLC_UNLK_D1     8'hAA
`define PFLC_UNLK_A2     17'h02AAA
`define PFLC_UNLK_D2     8'h55
`define PFLC_CMD_PROG    8'hA0
`define PFLC_CMD_ERASE   8'h80
`define PFLC_CMD_CHIP    8'h10
`define PFLC_CMD_SECT    8'h30
`define PFLC_CMD_IDENT   8'h90
`define PFLC_CMD_RESET   8'hF0
`define PFLC_SA_MSB      16
`define PFLC_SA_LSB      14
`define PFLC_DQ_POLL     7
`define PFLC_DQ_TOGGLE   6
`define PFLC_DQ_ERR      5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PFLC_CLK_NS      50
`define PFLC_T_WP_NS     100
`define PFLC_T_ACC_NS    150
`define PFLC_SYNC_DEPTH  3
`define PFLC_WP_CYC      ((`PFLC_T_WP_NS + `PFLC_CLK_NS - 1) / `PFLC_CLK_NS)
`define PFLC_ACC_CYC     ((`PFLC_T_ACC_NS + `PFLC_CLK_NS - 1) / `PFLC_CLK_NS)
`endif

// [pflc_pkg.sv]
`default_nettype none
package pflc_pkg;
    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_PROG   = 3'h1,
        OP_SERASE = 3'h2,
        OP_CERASE = 3'h3,
        OP_IDREAD = 3'h4,
        OP_RESET  = 3'h5
    } pflc_op_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_GAP    = 4'b1000
    } pflc_state_t;

    // one flash bus cycle
    typedef struct packed {
        logic        rd;
        logic [16:0] addr;
        logic [7:0]  data;
        logic        last;
    } pflc_cyc_t;

    // flash control strobes, all active low
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
    } pflc_pin_t;
endpackage
`default_nettype wire

// [pflc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// byte-wide flash behaviour: commands on write strobe edges, status while busy
module pflc_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_ID  = 8'hC3, // arbitrary value
    parameter logic [7:0] PROT_MAP = 8'h04,
    parameter int         BUSY_RDS = 3
) (
    input  wire logic [16:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        low_vcc,
    input  wire logic [7:0]  din,
    output var  logic [7:0]  dout
);
    logic [7:0]  mem [0:131071];
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  rd_val;
    logic [16:0] a_lat = 17'h00000;
    logic        id_mode = 1'b0;
    logic        tog = 1'b0;
    int          step = 0;
    int          busy = 0;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    always @(negedge we_n) if (!ce_n) a_lat = addr;
    // command decode on strobe rise, none at low supply
    always @(posedge we_n) if (!ce_n && oe_n && busy == 0 && !low_vcc) begin
        if (din == 8'hF0) begin
            step = 0;
            id_mode = 1'b0;
        end else if (step == 0 || step == 3)
            step = (a_lat[14:0] == 15'h5555 && din == 8'hAA) ? step + 1 : 0;
        else if (step == 1 || step == 4)
            step = (a_lat[14:0] == 15'h2AAA && din == 8'h55) ? step + 1 : 0;
        else if (step == 2) begin
            id_mode = (din == 8'h90);
            step = (a_lat[14:0] != 15'h5555) ? 0 : (din == 8'hA0) ? 6 : (din == 8'h80) ? 3 : 0;
        end else begin
            for (int i = 0; i < 131072; i++)
                if (!PROT_MAP[i[16:14]] && (step == 6 ? i == a_lat
                    : (din == 8'h10 || (din == 8'h30 && i[16:14] == a_lat[16:14]))))
                    mem[i] = (step == 6) ? (mem[i] & din) : 8'hFF;
            busy = BUSY_RDS;
            step = 0;
        end
    end
    always_comb begin
        if (busy != 0) rd_val = {1'b0, tog, 6'h00};
        else if (!id_mode) rd_val = mem[addr];
        else if (addr[1:0] == 2'd0) rd_val = MAKER_ID;
        else if (addr[1:0] == 2'd1) rd_val = PART_ID;
        else rd_val = {7'h00, PROT_MAP[addr[16:14]]};
    end
    // busy counts reads, deselect never aborts
    always @(posedge oe_n) if (!ce_n) begin
        last_q = rd_val;
        tog = ~tog;
        if (busy != 0) busy = busy - 1;
    end
    // released pins show inverse, not last value
    assign dout = (!ce_n && !oe_n) ? rd_val : ~last_q;
endmodule
`default_nettype wire

// [parallel_flash_bus_modes_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pflc_defs.svh"
module parallel_flash_bus_modes_bench;
    localparam logic [7:0] MK = 8'h5A; // arbitrary value
    localparam logic [7:0] PT = 8'hC3; // arbitrary value
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic clk_en = 1'b1, low_vcc = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [16:0] fa;
    logic [7:0] dq_out, dq_in;
    pflc_pkg::pflc_pin_t fc;
    int err_total = 0, checks_done = 0;
    pflc_ctrl pflc_ctrl_inst (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .byte_address_bus(fa), .flash_ctl(fc), .dq_out(dq_out), .dq_in(dq_in));
    pflc_flash_model #(.MAKER_ID(MK), .PART_ID(PT)) pflc_flash_model_inst (.addr(fa), .ce_n(fc.ce_n),
        .oe_n(fc.oe_n), .we_n(fc.we_n), .low_vcc(low_vcc), .din(dq_out), .dout(dq_in));
    initial forever #25 clk = ~clk;
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: waits for pready, the watchdog bounds this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // start one operation, poll status until done
    task automatic op(input pflc_pkg::pflc_op_t o, input logic [16:0] a, input logic [7:0] d,
                      output logic [31:0] s);
        logic e;
        apb(1'b1, `PFLC_OFS_ADDR, {15'h0, a}, s, e);
        apb(1'b1, `PFLC_OFS_WDATA, {24'h0, d}, s, e);
        apb(1'b1, `PFLC_OFS_CTRL, {25'h0, o, 4'h1}, s, e);
        do begin
            apb(1'b0, `PFLC_OFS_STAT, 32'h0, s, e);
        end while (s[1] !== 1'b1);
    endtask
    task automatic rdb(input pflc_pkg::pflc_op_t o, input logic [16:0] a, input logic [7:0] x, input string nm);
        logic [31:0] s;
        op(o, a, 8'h00, s);
        chk(nm, {21'h0, x, 3'b010}, {21'h0, s[15:8], s[2:0]});
    endtask
    // strobe combinations seen on the flash pins
    always @(negedge clk) if (arst_n && fc.we_n !== 1'b1 && (fc.oe_n !== 1'b1 || fc.ce_n !== 1'b0))
        chk("write strobe", 32'h1, 32'h0);
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        chk("idle pins", 32'hF, {28'h0, fc});
        apb(1'b0, `PFLC_OFS_STAT, 32'h0, q, e);
        chk("status", 32'h0, q);
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
        rdb(pflc_pkg::OP_READ, 17'h00010, 8'hFF, "blank");
    endtask
    task automatic t_prog;
        logic [31:0] s;
        op(pflc_pkg::OP_PROG, 17'h04001, 8'hA5, s);
        chk("prog status", 32'h2, {29'h0, s[2:0]});
        rdb(pflc_pkg::OP_READ, 17'h04001, 8'hA5, "prog byte");
        rdb(pflc_pkg::OP_READ, 17'h04002, 8'hFF, "neighbour");
        op(pflc_pkg::OP_PROG, 17'h0A000, 8'h00, s);
        rdb(pflc_pkg::OP_READ, 17'h0A000, 8'hFF, "protected");
        low_vcc <= 1'b1;
        op(pflc_pkg::OP_PROG, 17'h04003, 8'h00, s);
        low_vcc <= 1'b0;
        rdb(pflc_pkg::OP_READ, 17'h04003, 8'hFF, "low supply");
    endtask
    // clock enable low mid-read must hold the strobe and address pins, then the read finishes
    task automatic t_freeze;
        logic [31:0] s;
        logic [20:0] p;
        logic        e;
        apb(1'b1, `PFLC_OFS_ADDR, {15'h0, 17'h04001}, s, e);
        apb(1'b1, `PFLC_OFS_CTRL, {25'h0, pflc_pkg::OP_READ, 4'h1}, s, e);
        repeat (4) @(posedge clk);
        clk_en <= 1'b0;
        @(posedge clk);
        p = {fc, fa};
        repeat (10) @(posedge clk);
        chk("frozen pins", {11'h0, p}, {11'h0, fc, fa});
        clk_en <= 1'b1;
        repeat (20) @(posedge clk);
        apb(1'b0, `PFLC_OFS_STAT, 32'h0, s, e);
        chk("thawed read", 32'h0000A502, s);
    endtask
    task automatic t_ident;
        logic [31:0] s;
        rdb(pflc_pkg::OP_IDREAD, 17'h00000, MK, "maker");
        rdb(pflc_pkg::OP_IDREAD, 17'h00001, PT, "part");
        rdb(pflc_pkg::OP_IDREAD, 17'h08002, 8'h01, "prot set");
        rdb(pflc_pkg::OP_IDREAD, 17'h1C002, 8'h00, "prot clr");
        rdb(pflc_pkg::OP_READ, 17'h04001, 8'hA5, "after id");
        op(pflc_pkg::OP_RESET, 17'h00000, 8'h00, s);
        chk("reset op", 32'h2, {29'h0, s[2:0]});
    endtask
    task automatic t_erase;
        logic [31:0] s;
        op(pflc_pkg::OP_PROG, 17'h00003, 8'h3C, s);
        op(pflc_pkg::OP_SERASE, 17'h04000, 8'h00, s);
        rdb(pflc_pkg::OP_READ, 17'h04001, 8'hFF, "sector gone");
        rdb(pflc_pkg::OP_READ, 17'h00003, 8'h3C, "other kept");
        op(pflc_pkg::OP_CERASE, 17'h00000, 8'h00, s);
        rdb(pflc_pkg::OP_READ, 17'h00003, 8'hFF, "chip gone");
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_prog;
        t_ident;
        t_freeze;
        t_erase;
        stop_test;
    end
endmodule
`default_nettype wire
